// ===== kwi_defs.vh
// Purpose: Constants for the keypad wake interrupt block.
// Assumes: Plain register port with byte-wide registers.
// Notes:   Offsets are word indices on the register port.
`ifndef KWI_DEFS_VH
`define KWI_DEFS_VH
`define KWI_ADDR_W        3
`define KWI_OFF_STATCTL   3'h0
`define KWI_OFF_PINEN     3'h1
`define KWI_OFF_PORTDATA  3'h2
`define KWI_OFF_PORTDIR   3'h3
`define KWI_OFF_PULLEN    3'h4
`define KWI_OFF_PINLEVEL  3'h5
`define KWI_OFF_EVSTAT    3'h6
`define KWI_OFF_EVMASK    3'h7
`define KWI_BIT_MODE      0
`define KWI_BIT_IRQEN     1
`define KWI_BIT_ACK       2
`define KWI_BIT_PEND      3
`define KWI_POL_LSB       4
`define KWI_POL_MSB       7
`define KWI_EV_TRIGGER    0
`define KWI_EV_WAKE       1
`define KWI_RESET_BYTE    8'h00
`endif

// ===== kwi_keypad_wake_interrupt.v
// Purpose: Eight-input keypad interrupt sharing an 8-bit general-purpose port.
// Assumes: Pin inputs are synchronous to clk; stop mode is signalled by stopMode.
// Notes:   Pad outputs are registered; output enable is low while driving.
//
// Summary of operation
// - Per-pin enable selects keypad or GPIO.
// - Keypad-enabled pins forced to input direction.
// - Bits 3..0 always falling/low sensitive.
// - Upper polarity bits select rising/high when set.
// - Falling edge: sampled high then low.
// - Rising edge: sampled low then high.
// - Edge counts only from all-deasserted state.
// - Pending flag bit 3 set on trigger.
// - Ack bit 2 clears flag, reads zero.
// - Level mode keeps flag set while asserted.
// - Irq enable gates request; flag still pollable.
// - Mode bit: 0 edge-only, 1 edge-and-level.
// - In stop, enabled pins wake by level if irq enable is set; wakeReq is registered on clk.
// - Enabled interrupt wakes from wait and stop3.
// - Rising-polarity upper pins get pulldown not pullup.
`include "kwi_defs.vh"
module kwi_keypad_wake_interrupt #(
  parameter WIDTH = 8
) (
  input  wire                   clk,
  input  wire                   resetn,
  input  wire [`KWI_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWdata,
  input  wire                   regWrite,
  input  wire                   regRead,
  output reg  [7:0]             regRdata,
  input  wire [WIDTH-1:0]       padIn,
  output reg  [WIDTH-1:0]       padOut,
  output reg  [WIDTH-1:0]       padOen,
  output reg  [WIDTH-1:0]       padPullUp,
  output reg  [WIDTH-1:0]       padPullDown,
  input  wire                   stopMode,
  input  wire                   waitMode,
  output reg                    keypadIrq,
  output reg                    wakeReq,
  output reg                    eventIrq
);

  reg  [WIDTH-1:0] pinEnable_reg;
  reg  [3:0]       polSelect_reg;
  reg              irqEnable_reg;
  reg              detectMode_reg;
  reg              pending_reg;
  reg              pending_next;
  reg  [WIDTH-1:0] portData_reg;
  reg  [WIDTH-1:0] portDir_reg;
  reg  [WIDTH-1:0] pullEn_reg;
  reg  [WIDTH-1:0] sample_reg;
  reg  [1:0]       evStat_reg;
  reg  [1:0]       evMask_reg;
  reg  [1:0]       evStat_next;
  wire [WIDTH-1:0] risingPol;
  wire [WIDTH-1:0] asserted;
  wire [WIDTH-1:0] wasAsserted;
  wire             anyAsserted;
  wire             edgeSeen;
  wire             ackWrite;
  wire             trigger;
  wire             asyncWake;

  // Lower pins have no polarity select and always trigger on falling/low.
  assign risingPol = {polSelect_reg, 4'h0};

  // Asserted level per enabled pin, from the current and previous samples.
  function [WIDTH-1:0] assertMap;
    input [WIDTH-1:0] level;
    input [WIDTH-1:0] pol;
    input [WIDTH-1:0] en;
    begin
      assertMap = (level ~^ pol) & en;
    end
  endfunction

  assign asserted    = assertMap(padIn, risingPol, pinEnable_reg);
  assign wasAsserted = assertMap(sample_reg, risingPol, pinEnable_reg);
  assign anyAsserted = |asserted;
  // A new edge needs every enabled pin deasserted in the previous cycle.
  assign edgeSeen    = anyAsserted & ~(|wasAsserted);
  assign ackWrite    = regWrite & (regAddr == `KWI_OFF_STATCTL) & regWdata[`KWI_BIT_ACK];
  assign trigger     = edgeSeen | (detectMode_reg & anyAsserted);
  // In stop the edge sampler is bypassed; any enabled asserted pin wakes if irq enable is set.
  assign asyncWake   = stopMode & anyAsserted;

  always @* begin
    pending_next = pending_reg;
    if (ackWrite) begin
      pending_next = 1'b0;
    end
    // Set wins over acknowledge, so an edge in the ack cycle is kept.
    if (trigger) begin
      pending_next = 1'b1;
    end
  end

  always @* begin
    evStat_next = evStat_reg;
    if (regWrite && regAddr == `KWI_OFF_EVSTAT) begin
      evStat_next = evStat_reg & ~regWdata[1:0];
    end
    if (trigger) begin
      evStat_next[`KWI_EV_TRIGGER] = 1'b1;
    end
    if (asyncWake) begin
      evStat_next[`KWI_EV_WAKE] = 1'b1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinEnable_reg  <= `KWI_RESET_BYTE;
      polSelect_reg  <= 4'h0;
      irqEnable_reg  <= 1'b0;
      detectMode_reg <= 1'b0;
      pending_reg    <= 1'b0;
      portData_reg   <= `KWI_RESET_BYTE;
      portDir_reg    <= `KWI_RESET_BYTE;
      pullEn_reg     <= `KWI_RESET_BYTE;
      sample_reg     <= {WIDTH{1'b1}};
      evStat_reg     <= 2'h0;
      evMask_reg     <= 2'h0;
    end else begin
      sample_reg  <= padIn;
      pending_reg <= pending_next;
      evStat_reg  <= evStat_next;
      if (regWrite) begin
        case (regAddr)
          `KWI_OFF_STATCTL: begin
            polSelect_reg  <= regWdata[`KWI_POL_MSB:`KWI_POL_LSB];
            irqEnable_reg  <= regWdata[`KWI_BIT_IRQEN];
            detectMode_reg <= regWdata[`KWI_BIT_MODE];
          end
          `KWI_OFF_PINEN:    pinEnable_reg <= regWdata;
          `KWI_OFF_PORTDATA: portData_reg  <= regWdata;
          `KWI_OFF_PORTDIR:  portDir_reg   <= regWdata;
          `KWI_OFF_PULLEN:   pullEn_reg    <= regWdata;
          `KWI_OFF_EVMASK:   evMask_reg    <= regWdata[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Read data is registered and stands only in the cycle after the strobe.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `KWI_OFF_STATCTL:  regRdata <= {polSelect_reg, pending_reg, 1'b0, irqEnable_reg, detectMode_reg};
        `KWI_OFF_PINEN:    regRdata <= pinEnable_reg;
        `KWI_OFF_PORTDATA: regRdata <= portData_reg;
        `KWI_OFF_PORTDIR:  regRdata <= portDir_reg;
        `KWI_OFF_PULLEN:   regRdata <= pullEn_reg;
        `KWI_OFF_PINLEVEL: regRdata <= padIn;
        `KWI_OFF_EVSTAT:   regRdata <= {6'h00, evStat_reg};
        `KWI_OFF_EVMASK:   regRdata <= {6'h00, evMask_reg};
        default:           regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Pad controls. Pulls only act on pins that are inputs.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      padOut      <= {WIDTH{1'b0}};
      padOen      <= {WIDTH{1'b1}};
      padPullUp   <= {WIDTH{1'b0}};
      padPullDown <= {WIDTH{1'b0}};
      keypadIrq   <= 1'b0;
      wakeReq     <= 1'b0;
      eventIrq    <= 1'b0;
    end else begin
      padOut      <= portData_reg;
      padOen      <= ~(portDir_reg & ~pinEnable_reg);
      padPullUp   <= pullEn_reg & ~(portDir_reg & ~pinEnable_reg) & ~(risingPol & pinEnable_reg);
      padPullDown <= pullEn_reg & risingPol & pinEnable_reg;
      keypadIrq   <= pending_next & irqEnable_reg;
      // Wake from wait uses the gated request; stop uses the async level path.
      wakeReq     <= (waitMode & pending_next & irqEnable_reg) | (irqEnable_reg & asyncWake);
      eventIrq    <= |(evStat_next & evMask_reg);
    end
  end

endmodule // kwi_keypad_wake_interrupt

// ===== kwi_keypad_wake_interrupt_test.sv
// Purpose: Self-checking bench for the keypad wake interrupt.
// Assumes: Pulls are on for every pin so released keys idle.
// Notes:   Each pin is paired with its neighbour in each mode, under random polarity and irq enable.
`include "kwi_defs.vh"
module kwi_keypad_wake_interrupt_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       resetn, regWrite, regRead, stopMode, waitMode, ie, mode;
  logic [2:0] regAddr;
  logic [7:0] regWdata, press, hit, pe, pol, pd;
  wire  [7:0] regRdata, padIn, padOut, padOen, padPullUp, padPullDown;
  wire        keypadIrq, wakeReq, eventIrq;
  int         fails, check_count, cyc;
  kwi_keypad_wake_interrupt i_kwi_keypad_wake_interrupt (.*);
  kwi_keys i_kwi_keys (.*);
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc == 6000) begin
    fails++;
    give_verdict();
  end
  task automatic chk(string n, logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e, string n);
    @(posedge clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(n, regRdata, e);
  endtask
  function automatic logic [7:0] stat(logic p);
    return {pol[7:4], p, 1'b0, ie, mode};
  endfunction
  task automatic ack();
    wr(`KWI_OFF_STATCTL, stat(1'b0) | 8'h04);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {resetn, regWrite, regRead, stopMode, waitMode, press, hit, regAddr, regWdata} = '0;
    void'($urandom(67));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(`KWI_OFF_STATCTL, 8'h00, "sc");
    rd(`KWI_OFF_PINEN, 8'h00, "pe");
    wr(`KWI_OFF_PULLEN, 8'hFF);
    wr(`KWI_OFF_PORTDIR, 8'hFF);
    wr(`KWI_OFF_EVMASK, 8'h01);
    for (int k = 0; k < 16; k++) begin
      pe = (8'h01 << (k % 8)) | (8'h01 << ((k + 1) % 8));
      {pol, ie} = 9'($urandom);
      mode = k[3];
      hit = pol & 8'hF0;
      waitMode <= ie;
      wr(`KWI_OFF_STATCTL, stat(1'b0));
      wr(`KWI_OFF_PINEN, pe);
      pd = 8'($urandom);
      wr(`KWI_OFF_PORTDATA, pd);
      repeat (3) @(posedge clk);
      chk("oen", padOen, pe);
      chk("pulldown", padPullDown, pe & hit);
      chk("pullup", padPullUp, pe & ~hit);
      chk("padout", padOut, pd);
      rd(`KWI_OFF_PORTDATA, pd, "pdata");
      rd(`KWI_OFF_PINLEVEL, (pd & ~pe) | (pe & ~hit), "level");
      ack();
      rd(`KWI_OFF_STATCTL, stat(1'b0), "idle");
      press <= 8'h01 << (k % 8);
      repeat (4) @(posedge clk);
      chk("irq", keypadIrq, ie);
      chk("event", eventIrq, 1'b1);
      ack();
      rd(`KWI_OFF_STATCTL, stat(mode), "held");
      press <= pe;
      repeat (4) @(posedge clk);
      rd(`KWI_OFF_STATCTL, stat(mode), "second");
      stopMode <= 1'b1;
      repeat (3) @(posedge clk);
      chk("wake", wakeReq, ie);
      {stopMode, press} <= 9'h000;
      repeat (3) @(posedge clk);
      ack();
      wr(`KWI_OFF_EVSTAT, 8'h03);
      rd(`KWI_OFF_STATCTL, stat(1'b0), "clear");
      chk("event", eventIrq, 1'b0);
      $display("test %0d done", k);
    end
    give_verdict();
  end
endmodule // kwi_keypad_wake_interrupt_test

// ===== kwi_keys.sv
// Purpose: Key switches on the eight port pins.
// Assumes: A pressed key ties its pin to its hit level.
// Notes:   A pin with no pull flips each cycle so no stale level survives.
module kwi_keys (
  input  wire       clk,
  input  wire [7:0] press,
  input  wire [7:0] hit,
  input  wire [7:0] padOut,
  input  wire [7:0] padOen,
  input  wire [7:0] padPullUp,
  input  wire [7:0] padPullDown,
  output wire [7:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [7:0] lastReg = 8'hFF;
  wire [7:0] idle = ~padPullDown & (padPullUp | ~lastReg);
  assign padIn = (~padOen & padOut) | (padOen & ((press & hit) | (~press & idle)));
  always @(posedge clk) lastReg <= padIn;
endmodule // kwi_keys

// ===== kwi_props.sv
// Purpose: Port assertions for the keypad wake interrupt.
// Assumes: Control writes land at the edge that takes them.
// Notes:   Controls are shadowed from writes, so edges need stable controls.
`include "kwi_defs.vh"
module kwi_props (
  input wire                   clk,
  input wire                   resetn,
  input wire [`KWI_ADDR_W-1:0] regAddr,
  input wire [7:0]             regWdata,
  input wire                   regWrite,
  input wire                   regRead,
  input wire [7:0]             regRdata,
  input wire [7:0]             padIn,
  input wire [7:0]             padOen,
  input wire [7:0]             padPullDown,
  input wire                   keypadIrq
);
  reg  [7:0] peReg, scReg;
  wire [7:0] asr = peReg & ~(padIn ^ {scReg[7:4], 4'h0});
  always @(posedge clk or negedge resetn)
    if (!resetn) {peReg, scReg} <= 16'h0000;
    else if (regWrite && regAddr == `KWI_OFF_PINEN) peReg <= regWdata;
    else if (regWrite && regAddr == `KWI_OFF_STATCTL) scReg <= regWdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_calm; $stable(peReg) && $stable(scReg); endsequence
  sequence s_idle; asr == 8'h00 && $stable(peReg) && $stable(scReg); endsequence
  property p_ackrd; regRead && regAddr == `KWI_OFF_STATCTL |=> !regRdata[2]; endproperty
  a_ackrd: assert property (p_ackrd) else $error("ack bit read as one");
  property p_oen; s_calm |-> (padOen & peReg) == peReg; endproperty
  a_oen: assert property (p_oen) else $error("keypad pin driven");
  property p_pd; s_calm |-> (padPullDown & ~(peReg & {scReg[7:4], 4'h0})) == 8'h00; endproperty
  a_pd: assert property (p_pd) else $error("pulldown on wrong pin");
  property p_ieoff; !scReg[1] && !$past(scReg[1]) |-> !keypadIrq; endproperty
  a_ieoff: assert property (p_ieoff) else $error("request while disabled");
  property p_edge; scReg[1] && s_calm && $past(asr) == 8'h00 && asr != 8'h00 |-> ##[1:3] keypadIrq; endproperty
  a_edge: assert property (p_edge) else $error("edge not flagged");
  property p_level; (scReg[1] && scReg[0] && asr != 8'h00) [*3] |-> keypadIrq; endproperty
  a_level: assert property (p_level) else $error("level not held");
  property p_ack; regWrite && regAddr == `KWI_OFF_STATCTL && regWdata[2] && asr == 8'h00 && $past(asr) == 8'h00
    |=> !keypadIrq; endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear");
  property p_quiet; s_idle [*4] ##0 !keypadIrq |=> !keypadIrq; endproperty
  a_quiet: assert property (p_quiet) else $error("request without edge");
endmodule // kwi_props
bind kwi_keypad_wake_interrupt kwi_props i_kwi_props (.*);
